/* File: dv/rfs_monitor_model.sv */
`timescale 1ns/1ns
module rfs_monitor_model
	import rfs_pkg::*;
(
	input wire logic clock, // 250 MHz
	input wire rfs_pkg::rfs_monitor_type want, // levels asked by the bench
	output rfs_pkg::rfs_monitor_type monitors // analog levels seen by the block
);
	import rfs_pkg::*;
	// analog levels move away from the sampling edge, like a real comparator output
	initial monitors = '0;
	always @(negedge clock) begin
		monitors <= want;
	end
endmodule // rfs_monitor_model

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import rfs_pkg::*;
	localparam int SHORT = 8;
	logic clock = 0, rst = 1, ce = 1, rd_valid, linreg_summary_flag;
	logic [7:0] rd_data;
	rfs_monitor_type want = '0, monitors;
	rfs_reg_req_type req = '0;
	int errors = 0, num_checks = 0, cycles = 0;
	rfs_regs #(.SHORT_CYCLES(SHORT)) DUT (.clock(clock), .rst(rst), .ce(ce),
		.monitors(monitors), .reg_req(req), .rd_data(rd_data), .rd_valid(rd_valid),
		.linreg_summary_flag(linreg_summary_flag));
	rfs_monitor_model partner (.clock(clock), .want(want), .monitors(monitors));
	initial forever #2 clock = ~clock;
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// a hang stops here instead of running forever
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_cycles(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		req.wr_en = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clock);
		req.wr_en = 1'b0;
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock);
		req.rd_en = 1'b1;
		req.addr = a;
		@(negedge clock);
		check({7'h00, rd_valid}, 8'h01);
		check(rd_data, exp);
		req.rd_en = 1'b0;
	endtask
	// expected status byte, top or buck, from the monitor levels
	function automatic logic [7:0] exp_stat(input rfs_monitor_type m, input logic top);
		logic [7:0] t, b;
		t = 8'h00;
		b = 8'h00;
		t[RFS_POWER_GOOD_PIN_BIT] = m.power_good_pin;
		t[RFS_SYNC_CLOCK_BIT] = m.sync_clock_invalid;
		t[RFS_THERMAL_SHUTDOWN_BIT] = m.thermal_shutdown;
		t[RFS_THERMAL_WARNING_BIT] = m.thermal_warning;
		t[RFS_INPUT_OVERVOLTAGE_BIT] = m.input_overvoltage;
		b[RFS_CONVERTER1_ENABLED_BIT] = m.converter1_enabled;
		b[RFS_CONVERTER1_INVALID_BIT] = m.converter1_output_invalid;
		b[RFS_CONVERTER1_ILIM_BIT] = m.converter1_current_limit;
		b[RFS_CONVERTER0_ENABLED_BIT] = m.converter0_enabled;
		b[RFS_CONVERTER0_INVALID_BIT] = m.converter0_output_invalid;
		b[RFS_CONVERTER0_ILIM_BIT] = m.converter0_current_limit;
		return top ? t : b;
	endfunction
	// flag must be pending with summary, survive a zero write, then clear on one
	task automatic flag_case(input int bitn);
		rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h01 << bitn);
		check({7'h00, linreg_summary_flag}, 8'h01);
		wr(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h00);
		rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h01 << bitn);
		wr(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h01 << bitn);
		rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h00);
		check({7'h00, linreg_summary_flag}, 8'h00);
	endtask
	initial begin
		wait_cycles(4);
		rst = 1'b0;
		rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, RFS_LINREG_IRQ_FLAGS_RESET);
		rd_check(8'h40, RFS_UNMAPPED_READ);
		for (int i = 6; i < 17; i++) begin
			want = rfs_monitor_type'(17'h1 << i);
			wait_cycles(4);
			wr(RFS_TOP_MONITOR_STATUS_ADDR, 8'hFF);
			rd_check(RFS_TOP_MONITOR_STATUS_ADDR, exp_stat(want, 1'b1));
			rd_check(RFS_BUCK_STATUS_ADDR, exp_stat(want, 1'b0));
		end
		want = '0;
		wait_cycles(4);
		for (int k = 0; k < 2; k++) begin
			want.linreg_current_limit[k] = 1'b1;
			wait_cycles(5);
			wr(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h01 << (RFS_LINREG_STRIDE * k));
			rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h01 << (RFS_LINREG_STRIDE * k));
			want.linreg_current_limit[k] = 1'b0;
			wait_cycles(4);
			flag_case(RFS_LINREG0_CURRENT_LIMIT_BIT + RFS_LINREG_STRIDE * k);
			want.linreg_output_invalid[k] = 1'b1;
			wait_cycles(5);
			flag_case(RFS_LINREG0_POWER_GOOD_BIT + RFS_LINREG_STRIDE * k);
			want.linreg_output_invalid[k] = 1'b0;
			wait_cycles(5);
			flag_case(RFS_LINREG0_POWER_GOOD_BIT + RFS_LINREG_STRIDE * k);
			// a dip shorter than the qualification time must not latch
			want.linreg_below_short[k] = 1'b1;
			wait_cycles(SHORT - 2);
			want.linreg_below_short[k] = 1'b0;
			wait_cycles(6);
			rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h00);
			want.linreg_below_short[k] = 1'b1;
			wait_cycles(SHORT + 8);
			want.linreg_below_short[k] = 1'b0;
			wait_cycles(4);
			flag_case(RFS_LINREG0_SHORT_BIT + RFS_LINREG_STRIDE * k);
		end
		want.linreg_current_limit = 2'b11;
		wait_cycles(5);
		want.linreg_current_limit = 2'b00;
		wait_cycles(4);
		ce = 1'b0;
		wr(RFS_LINREG_IRQ_FLAGS_ADDR, 8'hFF);
		ce = 1'b1;
		rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h11);
		rst = 1'b1;
		wait_cycles(2);
		rst = 1'b0;
		rd_check(RFS_LINREG_IRQ_FLAGS_ADDR, 8'h00);
		tally_and_finish();
	end
endmodule // testbench

/* File: hw/rfs_regs.sv */
// Behaviour
// - flag bit 6 set on a power-good event of linear regulator one.
// - flag bit 5 latched when regulator one output stays below short level over 1 ms.
// - flag bit 4 latched whenever regulator one current limit is active.
// - flag bit 2 set on a power-good event of linear regulator zero.
// - flag bit 1 latched when regulator zero output stays below short level over 1 ms.
// - flag bit 0 latched whenever regulator zero current limit is active.
// - writing one clears a flag; flags reset to zero; bits 7 and 3 reserved.
// - top status bit 7 reads the power-good pin level.
// - top status bit 4 reads one while the external sync clock is invalid.
// - top status bit 3 reads the thermal shutdown comparator.
// - top status bit 2 reads the thermal warning comparator.
// - top status bit 1 reads the input overvoltage comparator.
// - buck status bit 7 reads converter one enabled.
// - buck status bit 6 reads converter one output invalid.
// - buck status bit 4 reads converter one current limit active.
// - buck status bit 3 reads converter zero enabled.
// - summary flag set while any regulator flag pends, clears when all clear.
// - buck status bit 2 converter zero invalid, bit 0 its current limit.
`timescale 1ns/1ns
module rfs_regs
	import rfs_pkg::*;
#(
	parameter int SHORT_CYCLES = rfs_pkg::RFS_SHORT_CYCLES
) (
	input wire logic clock, // 250 MHz
	input wire logic rst, // sync reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire rfs_pkg::rfs_monitor_type monitors, // raw analog monitor levels
	input wire rfs_pkg::rfs_reg_req_type reg_req, // register access request
	output logic [7:0] rd_data, // read data, registered
	output logic rd_valid, // one-cycle pulse with rd_data
	output logic linreg_summary_flag // any regulator flag pending
);
	import rfs_pkg::*;

	// monitors are asynchronous comparator outputs
	rfs_monitor_type mon_meta;
	rfs_monitor_type mon_s;
	logic [1:0] invalid_prev;
	logic [7:0] linreg_irq_flags;

	always_ff @(posedge clock) begin
		if (rst) begin
			mon_meta <= '0;
			mon_s <= '0;
		end else if (ce) begin
			mon_meta <= monitors;
			mon_s <= mon_meta;
		end
	end

	// per-regulator event detection
	wire [2:0] lr_set [2];
	wire [1:0] short_hit;
	wire [1:0] pg_event;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_linreg
			rfs_short_timer #(
				.CYCLES(SHORT_CYCLES)
			) u_short (
				.clock(clock),
				.rst(rst),
				.ce(ce),
				.below(mon_s.linreg_below_short[gi]),
				.expired(short_hit[gi])
			);
			assign pg_event[gi] = mon_s.linreg_output_invalid[gi] != invalid_prev[gi];
			assign lr_set[gi] = {pg_event[gi], short_hit[gi], mon_s.linreg_current_limit[gi]};
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			invalid_prev <= '0;
		end else if (ce) begin
			invalid_prev <= mon_s.linreg_output_invalid;
		end
	end

	wire [7:0] flag_set = {1'h0, lr_set[1], 1'h0, lr_set[0]};

	wire hit_flags = reg_req.addr == RFS_LINREG_IRQ_FLAGS_ADDR;
	wire hit_top = reg_req.addr == RFS_TOP_MONITOR_STATUS_ADDR;
	wire hit_buck = reg_req.addr == RFS_BUCK_STATUS_ADDR;
	wire wr_flags = reg_req.wr_en && hit_flags;

	wire [7:0] flag_clear = wr_flags ? (reg_req.wdata & RFS_LINREG_FLAGS_USED) : 8'h00;
	wire [7:0] next_flags = (linreg_irq_flags & ~flag_clear) | flag_set;

	always_ff @(posedge clock) begin
		if (rst) begin
			linreg_irq_flags <= RFS_LINREG_IRQ_FLAGS_RESET;
			linreg_summary_flag <= 1'h0;
		end else if (ce) begin
			linreg_irq_flags <= next_flags;
			linreg_summary_flag <= |next_flags;
		end
	end

	wire [7:0] top_monitor_status = {
		mon_s.power_good_pin, 2'h0, mon_s.sync_clock_invalid,
		mon_s.thermal_shutdown, mon_s.thermal_warning, mon_s.input_overvoltage, 1'h0};

	wire [7:0] buck_status = {
		mon_s.converter1_enabled, mon_s.converter1_output_invalid, 1'h0,
		mon_s.converter1_current_limit, mon_s.converter0_enabled,
		mon_s.converter0_output_invalid, 1'h0, mon_s.converter0_current_limit};

	wire [7:0] rd_mux = hit_flags ? linreg_irq_flags :
		hit_top ? top_monitor_status :
		hit_buck ? buck_status : RFS_UNMAPPED_READ;

	// flags read the pre-clear value when a read and clear share a cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'h0;
		end else if (ce) begin
			rd_valid <= reg_req.rd_en;
			if (reg_req.rd_en) begin
				rd_data <= rd_mux;
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	set_beats_clear_a: assert property (
		ce && wr_flags && reg_req.wdata[RFS_LINREG1_CURRENT_LIMIT_BIT]
		&& mon_s.linreg_current_limit[1] |=> linreg_irq_flags[RFS_LINREG1_CURRENT_LIMIT_BIT])
		else $error("flag lost while its fault was present during clear");

	write_one_clears_a: assert property (
		ce && wr_flags && reg_req.wdata[RFS_LINREG0_CURRENT_LIMIT_BIT]
		&& !flag_set[RFS_LINREG0_CURRENT_LIMIT_BIT]
		|=> !linreg_irq_flags[RFS_LINREG0_CURRENT_LIMIT_BIT])
		else $error("write one did not clear the flag");

	write_zero_holds_a: assert property (
		ce && wr_flags && !reg_req.wdata[RFS_LINREG0_SHORT_BIT]
		&& linreg_irq_flags[RFS_LINREG0_SHORT_BIT] |=> linreg_irq_flags[RFS_LINREG0_SHORT_BIT])
		else $error("write zero changed a flag");

	reserved_zero_a: assert property (
		linreg_irq_flags[7] == 1'h0 && linreg_irq_flags[3] == 1'h0)
		else $error("reserved flag bit set");

	summary_follows_a: assert property (
		linreg_summary_flag == (|linreg_irq_flags))
		else $error("summary flag disagrees with flags");

	pg_event_one_a: assert property (
		ce && mon_s.linreg_output_invalid[1] != $past(mon_s.linreg_output_invalid[1])
		&& $past(ce) |=> linreg_irq_flags[RFS_LINREG1_POWER_GOOD_BIT])
		else $error("power-good event on regulator one not latched");

	pg_event_zero_a: assert property (
		ce && pg_event[0] |=> linreg_irq_flags[RFS_LINREG0_POWER_GOOD_BIT])
		else $error("power-good event on regulator zero not latched");

	short_one_a: assert property (
		ce && short_hit[1] |=> linreg_irq_flags[RFS_LINREG1_SHORT_BIT])
		else $error("short on regulator one not latched");

	short_zero_a: assert property (
		ce && short_hit[0] |=> linreg_irq_flags[RFS_LINREG0_SHORT_BIT])
		else $error("short on regulator zero not latched");

	ilim_one_a: assert property (
		ce && mon_s.linreg_current_limit[1] |=> linreg_irq_flags[RFS_LINREG1_CURRENT_LIMIT_BIT])
		else $error("current limit on regulator one not latched");

	ilim_zero_a: assert property (
		ce && mon_s.linreg_current_limit[0] |=> linreg_irq_flags[RFS_LINREG0_CURRENT_LIMIT_BIT])
		else $error("current limit on regulator zero not latched");

	top_read_a: assert property (
		ce && reg_req.rd_en && hit_top
		|=> rd_valid && rd_data[RFS_POWER_GOOD_PIN_BIT] == $past(mon_s.power_good_pin)
		&& rd_data[RFS_SYNC_CLOCK_BIT] == $past(mon_s.sync_clock_invalid))
		else $error("top status read wrong");

	buck_read_a: assert property (
		ce && reg_req.rd_en && hit_buck
		|=> rd_data[RFS_CONVERTER1_ENABLED_BIT] == $past(mon_s.converter1_enabled)
		&& rd_data[RFS_CONVERTER0_INVALID_BIT] == $past(mon_s.converter0_output_invalid)
		&& rd_data[1] == 1'h0)
		else $error("buck status read wrong");

	freeze_a: assert property (
		!ce |=> $stable(linreg_irq_flags) && $stable(rd_data))
		else $error("state changed while clock enable low");

	// checker-only run length of each low output, kept apart from the timer it checks
	int below_run [2];

	generate
		for (gi = 0; gi < 2; gi++) begin : g_run
			always_ff @(posedge clock) begin
				if (rst) begin
					below_run[gi] <= 0;
				end else if (ce) begin
					below_run[gi] <= !mon_s.linreg_below_short[gi] ? 0 :
						(below_run[gi] > SHORT_CYCLES) ? below_run[gi] : below_run[gi] + 1;
				end
			end
		end
	endgenerate

	short_time_one_a: assert property (
		short_hit[1] == (below_run[1] == SHORT_CYCLES + 1))
		else $error("regulator one short qualified at the wrong time");

	short_time_zero_a: assert property (
		short_hit[0] == (below_run[0] == SHORT_CYCLES + 1))
		else $error("regulator zero short qualified at the wrong time");

	ilim_quiet_a: assert property (
		ce && !linreg_irq_flags[RFS_LINREG0_CURRENT_LIMIT_BIT]
		&& !mon_s.linreg_current_limit[0]
		|=> !linreg_irq_flags[RFS_LINREG0_CURRENT_LIMIT_BIT])
		else $error("regulator zero current limit flag set without cause");

	short_quiet_a: assert property (
		ce && !linreg_irq_flags[RFS_LINREG0_SHORT_BIT] && !short_hit[0]
		|=> !linreg_irq_flags[RFS_LINREG0_SHORT_BIT])
		else $error("regulator zero short flag set without cause");

	pg_quiet_a: assert property (
		ce && $past(ce) && !linreg_irq_flags[RFS_LINREG1_POWER_GOOD_BIT]
		&& $stable(mon_s.linreg_output_invalid[1])
		|=> !linreg_irq_flags[RFS_LINREG1_POWER_GOOD_BIT])
		else $error("regulator one power-good flag set without an event");

	flags_read_a: assert property (
		ce && reg_req.rd_en && hit_flags |=> rd_valid && rd_data == $past(linreg_irq_flags))
		else $error("flag register read wrong");

	reset_values_a: assert property (
		$past(rst) |-> linreg_irq_flags == RFS_LINREG_IRQ_FLAGS_RESET
		&& !linreg_summary_flag && !rd_valid)
		else $error("state not at reset values after reset");

	unmapped_read_a: assert property (
		ce && reg_req.rd_en && !hit_flags && !hit_top && !hit_buck
		|=> rd_valid && rd_data == RFS_UNMAPPED_READ)
		else $error("unmapped read returned data");

	shutdown_read_a: assert property (
		ce && reg_req.rd_en && hit_top
		|=> rd_data[RFS_THERMAL_SHUTDOWN_BIT] == $past(mon_s.thermal_shutdown))
		else $error("thermal shutdown status read wrong");

	warning_read_a: assert property (
		ce && reg_req.rd_en && hit_top
		|=> rd_data[RFS_THERMAL_WARNING_BIT] == $past(mon_s.thermal_warning))
		else $error("thermal warning status read wrong");

	overvoltage_read_a: assert property (
		ce && reg_req.rd_en && hit_top
		|=> rd_data[RFS_INPUT_OVERVOLTAGE_BIT] == $past(mon_s.input_overvoltage))
		else $error("input overvoltage status read wrong");

	top_reserved_a: assert property (
		ce && reg_req.rd_en && hit_top |=> rd_data[6:5] == 2'h0 && !rd_data[0])
		else $error("reserved top status bit read as one");

	conv1_invalid_read_a: assert property (
		ce && reg_req.rd_en && hit_buck
		|=> rd_data[RFS_CONVERTER1_INVALID_BIT] == $past(mon_s.converter1_output_invalid))
		else $error("converter one validity read wrong");

	conv1_ilim_read_a: assert property (
		ce && reg_req.rd_en && hit_buck
		|=> rd_data[RFS_CONVERTER1_ILIM_BIT] == $past(mon_s.converter1_current_limit))
		else $error("converter one current limit read wrong");

	conv0_enable_read_a: assert property (
		ce && reg_req.rd_en && hit_buck
		|=> rd_data[RFS_CONVERTER0_ENABLED_BIT] == $past(mon_s.converter0_enabled))
		else $error("converter zero enable read wrong");

	conv0_ilim_read_a: assert property (
		ce && reg_req.rd_en && hit_buck
		|=> rd_data[RFS_CONVERTER0_ILIM_BIT] == $past(mon_s.converter0_current_limit))
		else $error("converter zero current limit read wrong");

	buck_reserved_a: assert property (
		ce && reg_req.rd_en && hit_buck |=> !rd_data[5] && !rd_data[1])
		else $error("reserved buck status bit read as one");

	read_pulse_a: assert property (
		ce && !reg_req.rd_en |=> !rd_valid)
		else $error("read valid without a read");

	status_write_ignored_a: assert property (
		ce && reg_req.wr_en && !hit_flags && flag_set == 8'h00
		|=> linreg_irq_flags == $past(linreg_irq_flags))
		else $error("write to a status register changed the flags");

endmodule // rfs_regs

/* File: hw/rfs_short_timer.sv */
`timescale 1ns/1ns
module rfs_short_timer #(
	parameter int CYCLES = rfs_pkg::RFS_SHORT_CYCLES
) (
	input wire logic clock, // 250 MHz
	input wire logic rst, // sync reset, active high
	input wire logic ce, // clock enable
	input wire logic below, // output below short threshold
	output logic expired // below held longer than CYCLES
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

	logic [CW-1:0] count;
	wire at_limit = (count == LIMIT);

	// saturating so a long short keeps expired high without wrapping
	always_ff @(posedge clock) begin
		if (rst) begin
			count <= '0;
			expired <= 1'h0;
		end else if (ce) begin
			count <= below ? (at_limit ? count : count + 1'h1) : '0;
			expired <= below && at_limit;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	short_needs_below_a: assert property (ce && $past(ce) && expired |-> $past(below))
		else $error("short timer expired without a held low output");

endmodule // rfs_short_timer

/* File: include/rfs_pkg.sv */
package rfs_pkg;

	// register offsets
	localparam logic [7:0] RFS_LINREG_IRQ_FLAGS_ADDR = 8'h1C;
	localparam logic [7:0] RFS_TOP_MONITOR_STATUS_ADDR = 8'h1D;
	localparam logic [7:0] RFS_BUCK_STATUS_ADDR = 8'h1E;

	// flag reset value and unmapped-address read value
	localparam logic [7:0] RFS_LINREG_IRQ_FLAGS_RESET = 8'h00;
	localparam logic [7:0] RFS_UNMAPPED_READ = 8'h00;

	// linreg_irq_flags fields
	localparam int RFS_LINREG1_POWER_GOOD_BIT = 6;
	localparam int RFS_LINREG1_SHORT_BIT = 5;
	localparam int RFS_LINREG1_CURRENT_LIMIT_BIT = 4;
	localparam int RFS_LINREG0_POWER_GOOD_BIT = 2;
	localparam int RFS_LINREG0_SHORT_BIT = 1;
	localparam int RFS_LINREG0_CURRENT_LIMIT_BIT = 0;
	localparam int RFS_LINREG_STRIDE = 4;
	localparam logic [7:0] RFS_LINREG_FLAGS_USED = 8'h77;

	// top_monitor_status fields
	localparam int RFS_POWER_GOOD_PIN_BIT = 7;
	localparam int RFS_SYNC_CLOCK_BIT = 4;
	localparam int RFS_THERMAL_SHUTDOWN_BIT = 3;
	localparam int RFS_THERMAL_WARNING_BIT = 2;
	localparam int RFS_INPUT_OVERVOLTAGE_BIT = 1;

	// buck_status fields
	localparam int RFS_CONVERTER1_ENABLED_BIT = 7;
	localparam int RFS_CONVERTER1_INVALID_BIT = 6;
	localparam int RFS_CONVERTER1_ILIM_BIT = 4;
	localparam int RFS_CONVERTER0_ENABLED_BIT = 3;
	localparam int RFS_CONVERTER0_INVALID_BIT = 2;
	localparam int RFS_CONVERTER0_ILIM_BIT = 0;

	// short-circuit qualification time
	localparam int RFS_CLOCK_MHZ = 250;
	localparam int RFS_SHORT_TIME_US = 1000;
	localparam int RFS_SHORT_CYCLES = RFS_SHORT_TIME_US * RFS_CLOCK_MHZ;

	// raw monitor levels from the analog side
	typedef struct packed {
		logic power_good_pin;
		logic sync_clock_invalid;
		logic thermal_shutdown;
		logic thermal_warning;
		logic input_overvoltage;
		logic converter1_enabled;
		logic converter1_output_invalid;
		logic converter1_current_limit;
		logic converter0_enabled;
		logic converter0_output_invalid;
		logic converter0_current_limit;
		logic [1:0] linreg_output_invalid;
		logic [1:0] linreg_current_limit;
		logic [1:0] linreg_below_short;
	} rfs_monitor_type;

	// register access from the serial port logic
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rfs_reg_req_type;

endpackage
